// ### nocl_config_loader.sv
// NVM-backed configuration loader with register port and offset compensation.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "nocl_regs.svh"

module nocl_config_loader
  import nocl_pkg::*;
#(
  parameter logic [7:0] NVM_PROG_CODE = `NOCL_CMD_NVM_PROG_DEF
)
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Pre-filter sample stream
  input wire logic raw_valid_in,
  input wire nocl_sample_type raw_sample_in,
  output logic raw_valid_out,
  output nocl_sample_type raw_sample_out,
  // Filtered sample stream
  input wire logic filt_valid_in,
  input wire nocl_sample_type filt_sample_in,
  output logic filt_valid_out,
  output nocl_sample_type filt_sample_out,
  // Sample and command status
  output logic sample_invalid_out,
  output logic cmd_ready_out
);

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SRST_CYC_INT = (`NOCL_SRST_DELAY_NS + `NOCL_CLK_NS - 1) / `NOCL_CLK_NS;
  localparam logic [7:0] SRST_CYC = SRST_CYC_INT[7:0];

  // ****************************************************************
  // State
  // ****************************************************************
  nocl_bus_req_type req;
  nocl_state_type state_reg;
  logic [7:0] nvm_mem [0:`NOCL_NVM_WORDS-1];
  logic [7:0] persistent_config_reg_reg;
  logic [7:0] off_x_reg;
  logic [7:0] off_y_reg;
  logic [7:0] off_z_reg;
  logic [7:0] nvm_ctl_reg;
  logic [7:0] power_config_reg_reg;
  logic [7:0] timer_reg;
  logic [1:0] idx_reg;
  logic off_written_reg;
  logic busy;
  logic wr_ok;
  logic [7:0] status_val;
  logic [7:0] read_val;
  logic cmd_prog;
  logic cmd_srst;

  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
  assign busy = (state_reg != ST_IDLE);
  // Writes during boot, load, program or soft reset are dropped.
  assign wr_ok = req.wr && !busy;
  assign cmd_prog = wr_ok && (req.addr == `NOCL_ADDR_CMD) && (req.wdata == NVM_PROG_CODE)
                    && nvm_ctl_reg[`NOCL_BIT_PROG_EN]
                    && !power_config_reg_reg[`NOCL_BIT_ADV_PS];
  assign cmd_srst = wr_ok && (req.addr == `NOCL_ADDR_CMD)
                    && (req.wdata == `NOCL_CMD_SOFTRESET);

  function automatic logic [7:0] image_word(input logic [1:0] i, input logic [7:0] c,
                                            input logic [7:0] x, input logic [7:0] y,
                                            input logic [7:0] z);
    begin
      case (i)
        2'h0: image_word = c;
        2'h1: image_word = x;
        2'h2: image_word = y;
        default: image_word = z;
      endcase
    end
  endfunction

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_reg <= ST_BOOT;
      timer_reg <= `NOCL_ZERO8;
      idx_reg <= 2'h0;
    end
    else
    begin
      case (state_reg)
        ST_BOOT:
        begin
          state_reg <= ST_LOAD;
          timer_reg <= `NOCL_NVM_STEP_CYC;
          idx_reg <= 2'h0;
        end
        ST_LOAD, ST_PROG:
        begin
          if (timer_reg != `NOCL_ZERO8)
          begin
            timer_reg <= timer_reg - 8'h01;
          end
          else
          begin
            timer_reg <= `NOCL_NVM_STEP_CYC;
            idx_reg <= idx_reg + 2'h1;
            if (idx_reg == 2'(`NOCL_NVM_WORDS - 1))
            begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_IDLE:
        begin
          if (cmd_srst)
          begin
            state_reg <= ST_SRST;
            timer_reg <= SRST_CYC;
          end
          else if (cmd_prog)
          begin
            state_reg <= ST_PROG;
            timer_reg <= `NOCL_NVM_STEP_CYC;
            idx_reg <= 2'h0;
          end
        end
        ST_SRST:
        begin
          if (timer_reg != `NOCL_ZERO8)
          begin
            timer_reg <= timer_reg - 8'h01;
          end
          else
          begin
            state_reg <= ST_BOOT;
          end
        end
        default:
        begin
          state_reg <= ST_BOOT;
        end
      endcase
    end
  end

  // ****************************************************************
  // NVM array
  // ****************************************************************
  // Contents survive both resets, as non-volatile storage should.
  // They hold unknown values until the first program, so the first boot loads unknown images.
  always_ff @(posedge clk_sys_in)
  begin
    if (state_reg == ST_PROG && timer_reg == `NOCL_ZERO8)
    begin
      nvm_mem[idx_reg] <= image_word(idx_reg, persistent_config_reg_reg, off_x_reg, off_y_reg,
                                     off_z_reg);
    end
  end

  // ****************************************************************
  // Image registers
  // ****************************************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || state_reg == ST_BOOT)
    begin
      persistent_config_reg_reg <= `NOCL_ZERO8;
      off_x_reg <= `NOCL_ZERO8;
      off_y_reg <= `NOCL_ZERO8;
      off_z_reg <= `NOCL_ZERO8;
    end
    else if (state_reg == ST_LOAD && timer_reg == `NOCL_ZERO8)
    begin
      case (idx_reg)
        2'h0: persistent_config_reg_reg <= nvm_mem[0];
        2'h1: off_x_reg <= nvm_mem[1];
        2'h2: off_y_reg <= nvm_mem[2];
        default: off_z_reg <= nvm_mem[3];
      endcase
    end
    else if (wr_ok)
    begin
      case (req.addr)
        `NOCL_ADDR_PERSISTENT_CONFIG_REG: persistent_config_reg_reg <= req.wdata;
        `NOCL_ADDR_OFF_X: off_x_reg <= req.wdata;
        `NOCL_ADDR_OFF_Y: off_y_reg <= req.wdata;
        `NOCL_ADDR_OFF_Z: off_z_reg <= req.wdata;
        default: persistent_config_reg_reg <= persistent_config_reg_reg;
      endcase
    end
  end

  // ****************************************************************
  // Volatile control registers
  // ****************************************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || state_reg == ST_BOOT)
    begin
      nvm_ctl_reg <= `NOCL_ZERO8;
      power_config_reg_reg <= `NOCL_POWER_CONFIG_REG_RST;
    end
    else if (wr_ok && req.addr == `NOCL_ADDR_NVM_CTL)
    begin
      nvm_ctl_reg <= req.wdata & (8'h01 << `NOCL_BIT_PROG_EN);
    end
    else if (wr_ok && req.addr == `NOCL_ADDR_POWER_CONFIG_REG)
    begin
      power_config_reg_reg <= req.wdata & 8'h03;
    end
  end

  // ****************************************************************
  // Invalid sample marking
  // ****************************************************************
  // A new write re-arms the flag even if a sample consumes it in the same cycle.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      off_written_reg <= 1'b0;
    end
    else if (wr_ok && (req.addr == `NOCL_ADDR_OFF_X || req.addr == `NOCL_ADDR_OFF_Y
                       || req.addr == `NOCL_ADDR_OFF_Z))
    begin
      off_written_reg <= 1'b1;
    end
    else if (raw_valid_in)
    begin
      off_written_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      sample_invalid_out <= 1'b0;
    end
    else if (raw_valid_in)
    begin
      sample_invalid_out <= off_written_reg;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  assign status_val = busy ? `NOCL_ZERO8 : (8'h01 << `NOCL_BIT_CMD_RDY);
  assign cmd_ready_out = !busy;

  always_comb
  begin
    case (req.addr)
      `NOCL_ADDR_STATUS: read_val = status_val;
      `NOCL_ADDR_PERSISTENT_CONFIG_REG: read_val = persistent_config_reg_reg;
      `NOCL_ADDR_OFF_X: read_val = off_x_reg;
      `NOCL_ADDR_OFF_Y: read_val = off_y_reg;
      `NOCL_ADDR_OFF_Z: read_val = off_z_reg;
      `NOCL_ADDR_NVM_CTL: read_val = nvm_ctl_reg;
      `NOCL_ADDR_POWER_CONFIG_REG: read_val = power_config_reg_reg;
      default: read_val = `NOCL_ZERO8;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= `NOCL_ZERO8;
    end
    else if (req.rd)
    begin
      reg_rdata_out <= busy ? status_val : read_val;
    end
  end

  // ****************************************************************
  // Offset compensation on both paths
  // ****************************************************************
  nocl_offset_comp u_raw_comp (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .enable_in(persistent_config_reg_reg[`NOCL_BIT_OFF_EN]),
    .off_x_in(off_x_reg),
    .off_y_in(off_y_reg),
    .off_z_in(off_z_reg),
    .valid_in(raw_valid_in),
    .sample_in(raw_sample_in),
    .valid_out(raw_valid_out),
    .sample_out(raw_sample_out)
  );

  nocl_offset_comp u_filt_comp (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .enable_in(persistent_config_reg_reg[`NOCL_BIT_OFF_EN]),
    .off_x_in(off_x_reg),
    .off_y_in(off_y_reg),
    .off_z_in(off_z_reg),
    .valid_in(filt_valid_in),
    .sample_in(filt_sample_in),
    .valid_out(filt_valid_out),
    .sample_out(filt_sample_out)
  );

endmodule

`default_nettype wire

// ### nocl_regs.svh
// Register map constants and operating summary of the NVM offset configuration loader.
// Summary of operation
// - The offset is subtracted from raw and filtered samples, saturating at the signed limits.
// - Each axis offset is an 8-bit two's complement value of 3.9 mg per LSB, spanning plus or minus half a g.
// - Offset scaling stays the same whatever acceleration range is selected.
// - Correction applies only while the offset enable bit of the persistent config is one.
// - The first sample after a host write to an offset register is flagged invalid.
// - Only persistent config and the three offsets have NVM copies, and their images are ordinary.
// - Every image update copies the NVM contents into the images, which the host may then overwrite.
// - After reset or soft reset the NVM is loaded and command ready reads zero until it completes.
// - Programming rewrites the whole NVM and command ready reads zero while it runs.
// - A program command only starts when advanced power save is zero.
// - Until the boot load has finished, host writes are dropped and reads return the status register.
// - During an NVM load or program writes are dropped and reads return the status register.
// - Code 0xb6 in the command register soft resets and reloads the configuration after a delay.
`ifndef NOCL_REGS_SVH
`define NOCL_REGS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define NOCL_ADDR_STATUS 8'h03
`define NOCL_ADDR_PERSISTENT_CONFIG_REG 8'h70
`define NOCL_ADDR_OFF_X 8'h71
`define NOCL_ADDR_OFF_Y 8'h72
`define NOCL_ADDR_OFF_Z 8'h73
`define NOCL_ADDR_NVM_CTL 8'h6a
`define NOCL_ADDR_POWER_CONFIG_REG 8'h7c
`define NOCL_ADDR_CMD 8'h7e

// ****************************************************************
// Fields, resets, commands and timing
// ****************************************************************
`define NOCL_BIT_OFF_EN 3
`define NOCL_BIT_PROG_EN 1
`define NOCL_BIT_ADV_PS 0
`define NOCL_BIT_CMD_RDY 4
`define NOCL_POWER_CONFIG_REG_RST 8'h03
`define NOCL_ZERO8 8'h00
`define NOCL_CMD_SOFTRESET 8'hb6
`define NOCL_CMD_NVM_PROG_DEF 8'ha0
`define NOCL_NVM_WORDS 4
`define NOCL_SRST_DELAY_NS 1000
`define NOCL_CLK_NS 8
`define NOCL_NVM_STEP_CYC 8'h04

`endif

// ### nocl_pkg.sv
// Types shared by the NVM offset configuration loader.
package nocl_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } nocl_bus_req_type;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } nocl_sample_type;

  typedef enum logic [4:0] {
    ST_BOOT = 5'b00001,
    ST_LOAD = 5'b00010,
    ST_IDLE = 5'b00100,
    ST_PROG = 5'b01000,
    ST_SRST = 5'b10000
  } nocl_state_type;

endpackage

// ### nocl_offset_comp.sv
// Per-axis offset subtraction with saturation for one sample stream.
`timescale 1ns/1ps
`default_nettype none

module nocl_offset_comp
  import nocl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Control
  input wire logic enable_in,
  input wire logic [7:0] off_x_in,
  input wire logic [7:0] off_y_in,
  input wire logic [7:0] off_z_in,
  // Sample stream
  input wire logic valid_in,
  input wire nocl_sample_type sample_in,
  output logic valid_out,
  output nocl_sample_type sample_out
);

  // Offset LSB equals 3.9 mg; samples are subtracted as given, with no scaling for range.
  function automatic logic signed [15:0] sub_sat(input logic signed [15:0] s,
                                                 input logic [7:0] off);
    logic signed [16:0] d;
    begin
      d = {s[15], s} - {{9{off[7]}}, off};
      if (d[16] != d[15])
      begin
        sub_sat = d[16] ? 16'sh8000 : 16'sh7fff;
      end
      else
      begin
        sub_sat = d[15:0];
      end
    end
  endfunction

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      valid_out <= 1'b0;
      sample_out <= '0;
    end
    else
    begin
      valid_out <= valid_in;
      if (valid_in)
      begin
        if (enable_in)
        begin
          sample_out.x <= sub_sat(sample_in.x, off_x_in);
          sample_out.y <= sub_sat(sample_in.y, off_y_in);
          sample_out.z <= sub_sat(sample_in.z, off_z_in);
        end
        else
        begin
          sample_out <= sample_in;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### nocl_sample_src.sv
// Model of the acceleration datapath that feeds both sample streams.
`timescale 1ns/1ps
`default_nettype none

module nocl_sample_src
  import nocl_pkg::*;
(
  // Request
  input wire logic go_in,
  input wire nocl_sample_type smp_in,
  // Streams
  output logic raw_valid_out,
  output nocl_sample_type raw_sample_out,
  output logic filt_valid_out,
  output nocl_sample_type filt_sample_out
);
  // ********
  // Drive
  // ********
  // Idle data is inverted so a stale sample is never taken for a fresh one.
  assign raw_valid_out = go_in;
  assign filt_valid_out = go_in;
  // Both paths carry one sample, so the shared correction shows as equal outputs.
  assign raw_sample_out = go_in ? smp_in : ~smp_in;
  assign filt_sample_out = go_in ? smp_in : ~smp_in;
endmodule
`default_nettype wire

// ### nocl_config_loader_checker.sv
// Port assertions for the NVM offset configuration loader.
`timescale 1ns/1ps
`default_nettype none
`include "nocl_regs.svh"

module nocl_config_loader_checker
  import nocl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Sample streams
  input wire logic raw_valid_in,
  input wire nocl_sample_type raw_sample_in,
  input wire logic raw_valid_out,
  input wire nocl_sample_type raw_sample_out,
  input wire logic filt_valid_in,
  input wire nocl_sample_type filt_sample_in,
  input wire logic filt_valid_out,
  input wire nocl_sample_type filt_sample_out,
  // Status
  input wire logic sample_invalid_out,
  input wire logic cmd_ready_out
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  property p_busy_rd;
    reg_rd_in && !cmd_ready_out |=> reg_rdata_out == 8'h00;
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy read wrong");
  property p_ready_rd;
    reg_rd_in && reg_addr_in == `NOCL_ADDR_STATUS && cmd_ready_out |=> reg_rdata_out[4];
  endproperty
  a_ready_rd: assert property (p_ready_rd) else $error("ready bit low");
  property p_raw_lat;
    raw_valid_in |=> raw_valid_out;
  endproperty
  a_raw_lat: assert property (p_raw_lat) else $error("raw valid lost");
  property p_filt_lat;
    filt_valid_in |=> filt_valid_out && $past(filt_valid_in);
  endproperty
  a_filt_lat: assert property (p_filt_lat) else $error("filt valid lost");
  property p_boot;
    $fell(rst_in) |-> !cmd_ready_out [*8];
  endproperty
  a_boot: assert property (p_boot) else $error("ready during boot");
  property p_srst;
    reg_wr_in && reg_addr_in == `NOCL_ADDR_CMD && reg_wdata_in == `NOCL_CMD_SOFTRESET
      && cmd_ready_out |=> !cmd_ready_out [*8];
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset ignored");
  property p_inv;
    reg_wr_in && cmd_ready_out && reg_addr_in inside {[8'h71:8'h73]} ##1 !raw_valid_in
      ##1 raw_valid_in |=> sample_invalid_out;
  endproperty
  a_inv: assert property (p_inv) else $error("sample not invalid");
  property p_same;
    raw_valid_in && filt_valid_in && raw_sample_in == filt_sample_in
      |=> raw_sample_out == filt_sample_out;
  endproperty
  a_same: assert property (p_same) else $error("paths differ");
endmodule

bind nocl_config_loader nocl_config_loader_checker u_nocl_config_loader_checker (.clk_sys_in,
  .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .raw_valid_in,
  .raw_sample_in, .raw_valid_out, .raw_sample_out, .filt_valid_in, .filt_sample_in,
  .filt_valid_out, .filt_sample_out, .sample_invalid_out, .cmd_ready_out);
`default_nettype wire

// ### test_nocl_config_loader.sv
// Self-checking bench for the NVM offset configuration loader.
`timescale 1ns/1ps
`default_nettype none
`include "nocl_regs.svh"

module test_nocl_config_loader
  import nocl_pkg::*;
;
  // ********
  // Signals
  // ********
  localparam logic [7:0] PROG = `NOCL_CMD_NVM_PROG_DEF;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic go = 1'b0;
  nocl_sample_type smp = '0;
  logic [7:0] reg_rdata_out;
  logic raw_valid_in, filt_valid_in, raw_valid_out, filt_valid_out;
  logic sample_invalid_out, cmd_ready_out, en;
  nocl_sample_type raw_sample_in, filt_sample_in, raw_sample_out, filt_sample_out;
  logic signed [15:0] sx, sy, sz;
  logic [7:0] ox, oy, oz, d;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 42909;

  nocl_sample_src u_nocl_sample_src (.go_in(go), .smp_in(smp), .raw_valid_out(raw_valid_in),
    .raw_sample_out(raw_sample_in), .filt_valid_out(filt_valid_in),
    .filt_sample_out(filt_sample_in));
  nocl_config_loader u_nocl_config_loader (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .raw_valid_in, .raw_sample_in, .raw_valid_out,
    .raw_sample_out, .filt_valid_in, .filt_sample_in, .filt_valid_out, .filt_sample_out,
    .sample_invalid_out, .cmd_ready_out);

  always #4 clk_sys_in = ~clk_sys_in;

  // The sequence needs under 400 cycles; the ceiling only catches a hang.
  always @(posedge clk_sys_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_total++;
      conclude();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_smp(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
    chk_reg(nm, e, d);
  endtask

  task automatic wait_rdy(input int lim);
    int n;
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    chk_bit("cmd_ready", 1'b1, cmd_ready_out);
  endtask

  // Sign-extended subtraction clamped to the 16-bit limits.
  function automatic logic [15:0] comp(input logic signed [15:0] s, input logic [7:0] o);
    int v;
    v = en ? int'(s) - int'($signed(o)) : int'(s);
    if (v > 32767)
      v = 32767;
    if (v < -32768)
      v = -32768;
    return 16'(v);
  endfunction

  task automatic send(input logic inv);
    @(posedge clk_sys_in);
    go <= 1'b1;
    smp <= '{sx, sy, sz};
    @(posedge clk_sys_in);
    go <= 1'b0;
    #1;
    chk_bit("invalid", inv, sample_invalid_out);
    chk_bit("valid", 1'b1, raw_valid_out);
    if (!inv)
    begin
      chk_smp("raw_x", comp(sx, ox), raw_sample_out.x);
      chk_smp("raw_y", comp(sy, oy), raw_sample_out.y);
      chk_smp("raw_z", comp(sz, oz), raw_sample_out.z);
      chk_bit("filt_valid", 1'b1, filt_valid_out);
      chk_smp("filt_x", comp(sx, ox), filt_sample_out.x);
      chk_smp("filt_y", comp(sy, oy), filt_sample_out.y);
      chk_smp("filt_z", comp(sz, oz), filt_sample_out.z);
    end
  endtask

  // ********
  // Sequence
  // ********
  initial
  begin
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1 chk_bit("boot", 1'b0, cmd_ready_out);
    rchk(`NOCL_ADDR_OFF_X, 8'h00, "boot_read");
    wait_rdy(40);
    $display("test boot done");
    rchk(`NOCL_ADDR_POWER_CONFIG_REG, `NOCL_POWER_CONFIG_REG_RST, "power_config_reg");
    rchk(8'h00, 8'h00, "unmapped");
    rchk(`NOCL_ADDR_STATUS, 8'h01 << `NOCL_BIT_CMD_RDY, "status");
    chk_bit("status_rdy", 1'b1, d[`NOCL_BIT_CMD_RDY]);
    wr(`NOCL_ADDR_CMD, 8'h55);
    chk_bit("unknown_cmd", 1'b1, cmd_ready_out);
    wr(`NOCL_ADDR_NVM_CTL, 8'h02);
    wr(`NOCL_ADDR_CMD, PROG);
    chk_bit("prog_ps", 1'b1, cmd_ready_out);
    // Relock, then leave power save so the images below precede the unlock.
    wr(`NOCL_ADDR_NVM_CTL, 8'h00);
    wr(`NOCL_ADDR_POWER_CONFIG_REG, 8'h02);
    $display("test commands done");
    for (int i = 0; i < 8; i++)
    begin
      ox = 8'($random(seed));
      oy = 8'($random(seed));
      oz = 8'($random(seed));
      sx = 16'($random(seed));
      sy = 16'($random(seed));
      sz = 16'($random(seed));
      if (i < 2)
        ox = i[0] ? 8'h80 : 8'h7f;
      if (i < 2)
        sx = i[0] ? 16'sh7fff : 16'sh8000;
      en = (i % 3) != 2;
      wr(`NOCL_ADDR_PERSISTENT_CONFIG_REG, {4'h0, en, 3'h0});
      wr(`NOCL_ADDR_OFF_X, ox);
      wr(`NOCL_ADDR_OFF_Y, oy);
      wr(`NOCL_ADDR_OFF_Z, oz);
      send(1'b1);
      send(1'b0);
      rchk(`NOCL_ADDR_OFF_Y, oy, "off_y");
    end
    $display("test offsets done");
    wr(`NOCL_ADDR_PERSISTENT_CONFIG_REG, 8'h08);
    wr(`NOCL_ADDR_NVM_CTL, 8'h02);
    wr(`NOCL_ADDR_CMD, PROG);
    chk_bit("prog_busy", 1'b0, cmd_ready_out);
    // The host writes power config while the command runs; the write is dropped and the read returns status.
    wr(`NOCL_ADDR_POWER_CONFIG_REG, 8'h03);
    rchk(`NOCL_ADDR_POWER_CONFIG_REG, 8'h00, "prog_read");
    wait_rdy(100);
    wr(`NOCL_ADDR_NVM_CTL, 8'h00);
    rchk(`NOCL_ADDR_POWER_CONFIG_REG, 8'h02, "drop_wr");
    rchk(`NOCL_ADDR_OFF_Y, oy, "prog_keep_y");
    $display("test program done");
    wr(`NOCL_ADDR_OFF_X, ~ox);
    wr(`NOCL_ADDR_PERSISTENT_CONFIG_REG, 8'h00);
    wr(`NOCL_ADDR_CMD, `NOCL_CMD_SOFTRESET);
    chk_bit("srst_busy", 1'b0, cmd_ready_out);
    wr(`NOCL_ADDR_OFF_Z, ~oz);
    wait_rdy(400);
    rchk(`NOCL_ADDR_OFF_X, ox, "load_x");
    rchk(`NOCL_ADDR_OFF_Z, oz, "load_z");
    rchk(`NOCL_ADDR_PERSISTENT_CONFIG_REG, 8'h08, "load_cfg");
    rchk(`NOCL_ADDR_POWER_CONFIG_REG, `NOCL_POWER_CONFIG_REG_RST, "srst_pwr");
    $display("test soft reset done");
    conclude();
  end
endmodule
`default_nettype wire
